// ### pkg/sepc_defs.svh
`ifndef SEPC_DEFS_SVH
`define SEPC_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define SEPC_IDX_LANE4      16'h05C8
`define SEPC_IDX_LANE5      16'h05C9
`define SEPC_IDX_LANE6      16'h05CA
`define SEPC_IDX_LANE7      16'h05CB
`define SEPC_IDX_CAL        16'h1222
`define SEPC_IDX_STARTUP    16'h1228
`define SEPC_IDX_LOL        16'h1262
`define SEPC_IDX_STATUS     16'h1300
`define SEPC_IDX_IRQ_STAT   16'h1301
`define SEPC_IDX_IRQ_MASK   16'h1302

// reset values
`define SEPC_RST_LANE       8'h00
`define SEPC_RST_CAL        8'h00
`define SEPC_RST_STARTUP    8'h0F
`define SEPC_RST_LOL        8'h00
`define SEPC_RST_MASK       8'h00

// command codes of the pll control registers
`define SEPC_CAL_NORMAL     8'h00
`define SEPC_CAL_RESTART    8'h04
`define SEPC_LOL_NORMAL     8'h00
`define SEPC_LOL_CLEAR      8'h80

// status register bits
`define SEPC_STAT_LOCKED    0
`define SEPC_STAT_LOST      1
`define SEPC_STAT_CAL       2

// interrupt bits
`define SEPC_IRQ_W          2
`define SEPC_IRQ_LOST       0
`define SEPC_IRQ_BACK       1

// bus encodings
`define SEPC_HTRANS_NONSEQ  2'h2
`define SEPC_HRESP_OKAY     1'h0
`define SEPC_IDX_LSB        2
`define SEPC_IDX_MSB        17

`endif

// ### pkg/sepc_pkg.sv
`default_nettype none

package sepc_pkg;

  // one lane emphasis register, bit 7 down to bit 0
  typedef struct packed {
    logic       postTapOn;
    logic [2:0] postTapLevel;
    logic [3:0] spare;
  } sepc_emph_s;

  // register selected by a bus address
  typedef enum logic [3:0] {
    SEL_NONE     = 4'h0,
    SEL_LANE4    = 4'h1,
    SEL_LANE5    = 4'h2,
    SEL_LANE6    = 4'h3,
    SEL_LANE7    = 4'h4,
    SEL_CAL      = 4'h5,
    SEL_STARTUP  = 4'h6,
    SEL_LOL      = 4'h7,
    SEL_STATUS   = 4'h8,
    SEL_IRQ_STAT = 4'h9,
    SEL_IRQ_MASK = 4'hA
  } sepc_sel_e;

  // bus transfer phase
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } sepc_state_e;

  // address phase captured for the data phase
  typedef struct packed {
    sepc_sel_e sel;
    logic      write;
  } sepc_req_s;

endpackage

`default_nettype wire

// ### core/sepc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sepc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] asyncIn,
  output var  logic [W-1:0] syncOut
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_syncOut;

  // stage one is read only by stage two
  always_comb begin
    next_stage1  = asyncIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= next_stage1;
      syncOut <= next_syncOut;
    end
  end

endmodule

`default_nettype wire

// ### core/sepc_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module sepc_irq_ctrl #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] eventIn,
  input  wire logic         readClear,
  input  wire logic [W-1:0] mask,
  output var  logic [W-1:0] status,
  output var  logic         irq
);

  logic [W-1:0] next_status;
  logic         next_irq;

  // a read clears, but an event in the same cycle sets again
  always_comb begin
    next_status = (readClear ? '0 : status) | eventIn;
    next_irq    = |(next_status & mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= next_irq;
    end
  end

endmodule

`default_nettype wire

// ### core/sepc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sepc_defs.svh"

//////////////////////////////////////////////////////////////////////////////
module sepc_regs #(
  parameter int LANES = 4
) (
  input  wire logic                               ref_clk,
  input  wire logic                               rst_n,
  // ahb-lite slave
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output var  logic [31:0]                        hrdata,
  output var  logic                               hreadyout,
  output var  logic                               hresp,
  // serial lanes four to seven
  output var  sepc_pkg::sepc_emph_s [LANES-1:0]   laneEmphasis,
  // serial-link pll
  input  wire logic                               pllLocked,
  output var  logic                               pllCalRestart,
  output var  logic [7:0]                         pllStartupCtrl,
  output var  logic                               pllLockLost,
  output var  logic                               irq
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read path and the write capture

  function automatic sepc_pkg::sepc_sel_e decodeSel(input logic [31:0] addr);
    logic [15:0] idx;
    idx = addr[`SEPC_IDX_MSB:`SEPC_IDX_LSB];
    decodeSel = sepc_pkg::SEL_NONE;
    // anything above the index field or off the word grid is unmapped
    if (addr[31:`SEPC_IDX_MSB+1] == '0 && addr[`SEPC_IDX_LSB-1:0] == '0) begin
      case (idx)
        `SEPC_IDX_LANE4:    decodeSel = sepc_pkg::SEL_LANE4;
        `SEPC_IDX_LANE5:    decodeSel = sepc_pkg::SEL_LANE5;
        `SEPC_IDX_LANE6:    decodeSel = sepc_pkg::SEL_LANE6;
        `SEPC_IDX_LANE7:    decodeSel = sepc_pkg::SEL_LANE7;
        `SEPC_IDX_CAL:      decodeSel = sepc_pkg::SEL_CAL;
        `SEPC_IDX_STARTUP:  decodeSel = sepc_pkg::SEL_STARTUP;
        `SEPC_IDX_LOL:      decodeSel = sepc_pkg::SEL_LOL;
        `SEPC_IDX_STATUS:   decodeSel = sepc_pkg::SEL_STATUS;
        `SEPC_IDX_IRQ_STAT: decodeSel = sepc_pkg::SEL_IRQ_STAT;
        `SEPC_IDX_IRQ_MASK: decodeSel = sepc_pkg::SEL_IRQ_MASK;
        default:            decodeSel = sepc_pkg::SEL_NONE;
      endcase
    end
  endfunction

  // lane register index of a select, or LANES when it is no lane
  function automatic int laneOf(input sepc_pkg::sepc_sel_e sel);
    case (sel)
      sepc_pkg::SEL_LANE4: laneOf = 0;
      sepc_pkg::SEL_LANE5: laneOf = 1;
      sepc_pkg::SEL_LANE6: laneOf = 2;
      sepc_pkg::SEL_LANE7: laneOf = 3;
      default:             laneOf = LANES;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  sepc_pkg::sepc_state_e              state;
  sepc_pkg::sepc_state_e              next_state;
  sepc_pkg::sepc_req_s                req;
  sepc_pkg::sepc_req_s                next_req;
  sepc_pkg::sepc_sel_e                addrSel;
  logic                               addrPhase;
  logic [31:0]                        next_hrdata;
  logic                               next_hreadyout;
  logic                               next_hresp;

  sepc_pkg::sepc_emph_s [LANES-1:0]   next_laneEmphasis;
  logic [7:0]                         calCtrl;
  logic [7:0]                         next_calCtrl;
  logic [7:0]                         next_pllStartupCtrl;
  logic [7:0]                         lolCtrl;
  logic [7:0]                         next_lolCtrl;
  logic [`SEPC_IRQ_W-1:0]             irqMask;
  logic [`SEPC_IRQ_W-1:0]             next_irqMask;
  logic                               next_pllCalRestart;

  logic                               lockedSync;
  logic                               lockedPrev;
  logic                               next_lockedPrev;
  logic                               next_pllLockLost;
  logic [`SEPC_IRQ_W-1:0]             irqEvents;
  logic [`SEPC_IRQ_W-1:0]             irqStatus;
  logic                               irqReadClear;
  logic [7:0]                         statusByte;

  //////////////////////////////////////////////////////////////////////////////
  // lock input crosses in from the analog pll

  sepc_sync2 #(
    .W (1)
  ) u_lock_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn (pllLocked),
    .syncOut (lockedSync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus phase tracking

  assign addrPhase = hsel && hready && (htrans == `SEPC_HTRANS_NONSEQ);
  assign addrSel   = decodeSel(haddr);

  // zero wait states: hreadyout stays high, response always okay
  always_comb begin
    next_state     = state;
    next_req       = req;
    next_hreadyout = 1'b1;
    next_hresp     = `SEPC_HRESP_OKAY;
    if (hready) begin
      next_state     = sepc_pkg::ST_IDLE;
      next_req.sel   = sepc_pkg::SEL_NONE;
      next_req.write = 1'b0;
      if (addrPhase) begin
        next_state     = hwrite ? sepc_pkg::ST_WRITE : sepc_pkg::ST_READ;
        next_req.sel   = addrSel;
        next_req.write = hwrite;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state     <= sepc_pkg::ST_IDLE;
      req       <= '{sel: sepc_pkg::SEL_NONE, write: 1'b0};
      hreadyout <= 1'b1;
      hresp     <= `SEPC_HRESP_OKAY;
    end else begin
      state     <= next_state;
      req       <= next_req;
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register writes land in the data phase, from the low byte of hwdata

  always_comb begin
    next_laneEmphasis = laneEmphasis;
    next_calCtrl      = calCtrl;
    next_lolCtrl      = lolCtrl;
    next_irqMask      = irqMask;
    next_pllStartupCtrl = pllStartupCtrl;
    if (state == sepc_pkg::ST_WRITE) begin
      for (int i = 0; i < LANES; i++) begin
        if (laneOf(req.sel) == i) begin
          next_laneEmphasis[i] = sepc_pkg::sepc_emph_s'(hwdata[7:0]);
        end
      end
      case (req.sel)
        sepc_pkg::SEL_CAL:      next_calCtrl        = hwdata[7:0];
        sepc_pkg::SEL_STARTUP:  next_pllStartupCtrl = hwdata[7:0];
        sepc_pkg::SEL_LOL:      next_lolCtrl        = hwdata[7:0];
        sepc_pkg::SEL_IRQ_MASK: next_irqMask        = hwdata[`SEPC_IRQ_W-1:0];
        default:                next_calCtrl        = calCtrl;
      endcase
    end
    next_pllCalRestart = (next_calCtrl == `SEPC_CAL_RESTART);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < LANES; i++) begin
        laneEmphasis[i] <= sepc_pkg::sepc_emph_s'(`SEPC_RST_LANE);
      end
      calCtrl        <= `SEPC_RST_CAL;
      pllStartupCtrl <= `SEPC_RST_STARTUP;
      lolCtrl        <= `SEPC_RST_LOL;
      irqMask        <= `SEPC_IRQ_W'(`SEPC_RST_MASK);
      pllCalRestart  <= 1'b0;
    end else begin
      laneEmphasis   <= next_laneEmphasis;
      calCtrl        <= next_calCtrl;
      pllStartupCtrl <= next_pllStartupCtrl;
      lolCtrl        <= next_lolCtrl;
      irqMask        <= next_irqMask;
      pllCalRestart  <= next_pllCalRestart;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // lock-lost tracking

  // holding the clear code keeps the flag down, so software must write
  // the normal code again before a new loss can be seen
  always_comb begin
    next_lockedPrev  = lockedSync;
    next_pllLockLost = pllLockLost;
    if (lockedPrev && !lockedSync) begin
      next_pllLockLost = 1'b1;
    end
    if (lolCtrl == `SEPC_LOL_CLEAR) begin
      next_pllLockLost = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lockedPrev  <= 1'b0;
      pllLockLost <= 1'b0;
    end else begin
      lockedPrev  <= next_lockedPrev;
      pllLockLost <= next_pllLockLost;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: loss and regain of lock

  assign irqEvents[`SEPC_IRQ_LOST] = lockedPrev && !lockedSync;
  assign irqEvents[`SEPC_IRQ_BACK] = !lockedPrev && lockedSync;
  assign irqReadClear = addrPhase && !hwrite && (addrSel == sepc_pkg::SEL_IRQ_STAT);

  sepc_irq_ctrl #(
    .W (`SEPC_IRQ_W)
  ) u_irq (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .eventIn   (irqEvents),
    .readClear (irqReadClear),
    .mask      (irqMask),
    .status    (irqStatus),
    .irq       (irq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read data, latched at the address phase so it stands in the data phase

  always_comb begin
    statusByte = 8'h00;
    statusByte[`SEPC_STAT_LOCKED] = lockedSync;
    statusByte[`SEPC_STAT_LOST]   = pllLockLost;
    statusByte[`SEPC_STAT_CAL]    = pllCalRestart;
  end

  // unmapped addresses read zero; narrow registers zero-extend
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (addrPhase && !hwrite) begin
      for (int i = 0; i < LANES; i++) begin
        if (laneOf(addrSel) == i) begin
          next_hrdata[7:0] = laneEmphasis[i];
        end
      end
      case (addrSel)
        sepc_pkg::SEL_CAL:      next_hrdata[7:0] = calCtrl;
        sepc_pkg::SEL_STARTUP:  next_hrdata[7:0] = pllStartupCtrl;
        sepc_pkg::SEL_LOL:      next_hrdata[7:0] = lolCtrl;
        sepc_pkg::SEL_STATUS:   next_hrdata[7:0] = statusByte;
        sepc_pkg::SEL_IRQ_STAT: next_hrdata[`SEPC_IRQ_W-1:0] = irqStatus;
        sepc_pkg::SEL_IRQ_MASK: next_hrdata[`SEPC_IRQ_W-1:0] = irqMask;
        default:                next_hrdata[31:8] = 24'h00_0000;
      endcase
    end else if (!hready) begin
      next_hrdata = hrdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule

`default_nettype wire

// ### bench/sepc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module sepc_regs_sva #(
  parameter int LANES = 4
) (
  input wire logic                           ref_clk,
  input wire logic                           rst_n,
  input wire logic                           hsel,
  input wire logic [31:0]                    haddr,
  input wire logic [1:0]                     htrans,
  input wire logic                           hwrite,
  input wire logic [2:0]                     hsize,
  input wire logic [31:0]                    hwdata,
  input wire logic                           hready,
  input wire logic [31:0]                    hrdata,
  input wire logic                           hreadyout,
  input wire logic                           hresp,
  input wire sepc_pkg::sepc_emph_s [LANES-1:0] laneEmphasis,
  input wire logic                           pllLocked,
  input wire logic                           pllCalRestart,
  input wire logic [7:0]                     pllStartupCtrl,
  input wire logic                           pllLockLost,
  input wire logic                           irq
);
  logic        wrPend;
  logic        rdPend;
  logic [31:0] wrAddr;
  logic [7:0]  calCopy;
  logic [7:0]  lolCopy;
  wire         take = hsel && hready && (htrans == 2'h2);

  // copies of the two command registers, so the cal rule sees its code and the lock rules know when clear is held
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      calCopy <= 8'h00;
      lolCopy <= 8'h00;
    end else begin
      wrPend <= take && hwrite;
      rdPend <= take && !hwrite;
      wrAddr <= haddr;
      if (wrPend && wrAddr == 32'h0000_4888) calCopy <= hwdata[7:0];
      if (wrPend && wrAddr == 32'h0000_4988) lolCopy <= hwdata[7:0];
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // reset runs with the reset itself, so it cannot be disabled by it
  reset_values_a: assert property (disable iff (1'b0) !rst_n |=> laneEmphasis == '0
    && pllStartupCtrl == 8'h0F && !pllCalRestart && !pllLockLost && !irq)
    else $error("outputs not at reset values");
  zero_wait_a: assert property (hreadyout) else $error("wait state inserted");
  resp_okay_a: assert property (!hresp) else $error("error response given");
  cal_level_a: assert property (pllCalRestart == (calCopy == 8'h04))
    else $error("calibration restart does not follow its register");
  lost_sets_a: assert property ($fell(pllLocked) && lolCopy != 8'h80 |-> ##[1:3] pllLockLost)
    else $error("lock loss not flagged");
  lost_sticky_a: assert property (pllLockLost && lolCopy != 8'h80 |=> pllLockLost)
    else $error("lock-lost flag dropped without clear");
  lol_clear_a: assert property (lolCopy == 8'h80 |=> !pllLockLost)
    else $error("lock-lost flag not cleared");
  read_idle_a: assert property (!rdPend |-> hrdata == 32'h0) else $error("read data outside phase");
  read_upper_a: assert property (rdPend |-> hrdata[31:8] == 24'h0) else $error("upper read bits set");

  // main scenarios
  cover property ($rose(pllLockLost));
  cover property ($rose(irq));
  cover property ($rose(pllCalRestart));
endmodule

bind sepc_regs sepc_regs_sva #(.LANES(LANES)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .laneEmphasis(laneEmphasis), .pllLocked(pllLocked),
  .pllCalRestart(pllCalRestart), .pllStartupCtrl(pllStartupCtrl), .pllLockLost(pllLockLost),
  .irq(irq)
);

`default_nettype wire

// ### bench/test_serdes_emphasis_pll_ctrl_regs.sv
`timescale 1ns/1ps
`default_nettype none

module test_serdes_emphasis_pll_ctrl_regs;
  logic                       ref_clk, rst_n, hsel, hwrite, pllLocked, hready;
  logic                       hreadyout, hresp, pllCalRestart, pllLockLost, irq;
  logic [1:0]                 htrans;
  logic [2:0]                 hsize;
  logic [7:0]                 pllStartupCtrl, v;
  logic [31:0]                haddr, hwdata, hrdata, rd;
  sepc_pkg::sepc_emph_s [3:0] laneEmphasis;
  logic [15:0]                regIdx [7] = '{16'h05C8, 16'h05C9, 16'h05CA, 16'h05CB,
                                             16'h1222, 16'h1228, 16'h1262};
  logic [7:0]                 rstVal [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h00};
  int                         bad_count, tests_run, cycles;

  assign hready = hreadyout;

  sepc_regs #(.LANES(4)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .laneEmphasis(laneEmphasis), .pllLocked(pllLocked),
    .pllCalRestart(pllCalRestart), .pllStartupCtrl(pllStartupCtrl), .pllLockLost(pllLockLost),
    .irq(irq)
  );

  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one single transfer; ready and read data are taken at the rising edge itself,
  // before the slave's own updates of that edge land
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // a write is given one spare edge so that outputs have settled on return
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
    tick(1);
  endtask

  task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // hang guard, far above the roughly 215 cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    pllLocked = 1'b1;
    {cycles, bad_count, tests_run} = '0;
    tick(4);
    rst_n <= 1'b1;
    tick(1);
    // reset values, then an unmapped word that ignores writes
    for (int i = 0; i < 7; i++) rdChk(regIdx[i], {24'h0, rstVal[i]});
    wr(16'h1234, 8'hFF);
    rdChk(16'h1234, 32'h0);
    rdChk(16'h1301, 32'h2);
    // level codes 0 to 4 on every lane, spare bits carry the lane number
    for (int l = 0; l < 4; l++) begin
      for (int c = 0; c < 5; c++) begin
        v = {1'b1, c[2:0], l[3:0]};
        wr(regIdx[l], v);
        rdChk(regIdx[l], {24'h0, v});
        check({24'h0, laneEmphasis[l]}, {24'h0, v});
      end
    end
    for (int l = 0; l < 4; l++) check({24'h0, laneEmphasis[l]}, {28'h0C, l[3:0]});
    wr(16'h05CB, 8'h40);
    check({31'h0, laneEmphasis[3].postTapOn}, 32'h0);
    // calibration restart is a level held by code 0x04 only
    wr(16'h1222, 8'h04);
    check({31'h0, pllCalRestart}, 32'h1);
    rdChk(16'h1300, 32'h5);
    wr(16'h1222, 8'h05);
    check({31'h0, pllCalRestart}, 32'h0);
    rdChk(16'h1222, 32'h5);
    wr(16'h1222, 8'h00);
    wr(16'h1228, 8'h3C);
    check({24'h0, pllStartupCtrl}, 32'h3C);
    wr(16'h1228, 8'h0F);
    // lock loss with the interrupt unmasked, then relock
    wr(16'h1302, 8'h01);
    pllLocked <= 1'b0;
    tick(6);
    check({30'h0, pllLockLost, irq}, 32'h3);
    rdChk(16'h1300, 32'h2);
    rdChk(16'h1301, 32'h1);
    tick(1);
    check({31'h0, irq}, 32'h0);
    pllLocked <= 1'b1;
    tick(6);
    check({30'h0, pllLockLost, irq}, 32'h2);
    rdChk(16'h1301, 32'h2);
    // the clear code drops the flag and keeps it down while held
    wr(16'h1262, 8'h80);
    tick(1);
    check({31'h0, pllLockLost}, 32'h0);
    pllLocked <= 1'b0;
    tick(6);
    check({30'h0, pllLockLost, irq}, 32'h1);
    rdChk(16'h1301, 32'h1);
    rdChk(16'h1262, 32'h80);
    wr(16'h1262, 8'h00);
    wr(16'h1302, 8'h00);
    rdChk(16'h1302, 32'h0);
    pllLocked <= 1'b1;
    tick(6);
    pllLocked <= 1'b0;
    tick(6);
    check({30'h0, pllLockLost, irq}, 32'h2);
    // reset in mid-run restores the defaults; move the startup and calibration registers off them first
    wr(16'h1228, 8'h5A);
    wr(16'h1222, 8'h04);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    check(laneEmphasis, 32'h0);
    check({31'h0, pllCalRestart}, 32'h0);
    check({23'h0, pllStartupCtrl, pllLockLost}, 32'h1E);
    rdChk(16'h05C9, 32'h0);
    results();
  end
endmodule

`default_nettype wire
